// ---- flash_guard_pkg.sv ----
// Constants for the flash write-guard and query host controller
package flash_guard_pkg;
    localparam int          ADDR_W          = 20;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  CMD_QUERY       = 8'h98;
    localparam logic [7:0]  CMD_RESET       = 8'hF0;
    localparam logic [7:0]  CMD_UNLOCK1     = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_SEC_ENTER   = 8'h88;
    localparam logic [7:0]  CMD_SEC_EXIT    = 8'h90;
    localparam logic [7:0]  CMD_SEC_EXIT2   = 8'h00;
    localparam logic [11:0] ADDR_UNLOCK1_W  = 12'h555;
    localparam logic [11:0] ADDR_UNLOCK2_W  = 12'h2AA;
    localparam logic [11:0] ADDR_QUERY_W    = 12'h055;
    localparam logic [11:0] ADDR_QUERY_B    = 12'h0AA;
    localparam logic [7:0]  QRY_FIRST       = 8'h10;
    localparam logic [7:0]  QRY_LAST        = 8'h26;
    localparam int          STROBE_MIN_NS   = 5;
    localparam int          SETUP_MIN_NS    = 40;
    localparam int          READ_ACC_NS     = 85;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          STROBE_CYC      =
        (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETUP_CYC       =
        (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          READ_CYC        =
        (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 8;
    typedef enum logic [2:0]
    {
        OP_WRITE,
        OP_READ,
        OP_QUERY_ENTER,
        OP_RESET,
        OP_SEC_ENTER,
        OP_SEC_EXIT
    } op_t;
    typedef enum logic [2:0]
    {
        MODE_ARRAY,
        MODE_QUERY,
        MODE_QUERY_AUTO,
        MODE_AUTOSELECT,
        MODE_SECURED
    } mode_t;
endpackage

// ---- flash_guard_host.sv ----
// Host bus controller driving the flash command pins for guard and query operations
`timescale 1ns/1ps
`default_nettype none
module flash_guard_host #(
    parameter int ADDR_W  = flash_guard_pkg::ADDR_W,
    parameter int DATA_W  = flash_guard_pkg::DATA_W
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              en_i,
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic [2:0]        req_op_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_data_i,
    input  wire logic              byte_mode_i,
    input  wire logic              dev_busy_i,
    input  wire logic              supply_ok_i,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_data_o,
    output logic                   rsp_err_o,
    output logic [2:0]             mode_o,
    output logic                   ce_n_o,
    output logic                   we_n_o,
    output logic                   oe_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe_o,
    input  wire logic [DATA_W-1:0] dq_i
);
    typedef enum
    {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD,
        S_READ
    } state_t;

    localparam int            CNT_W_L = flash_guard_pkg::CNT_W;
    state_t                   state_q, state_d;
    logic [CNT_W_L-1:0]       cnt_q, cnt_d;
    logic [1:0]               step_q, step_d;
    logic [1:0]               nsteps_q, nsteps_d;
    logic [2:0]               op_q, op_d;
    logic [ADDR_W-1:0]        uaddr_q, uaddr_d;
    logic [DATA_W-1:0]        udata_q, udata_d;
    flash_guard_pkg::mode_t   mode_q, mode_d;
    logic                     ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic [ADDR_W-1:0]        addr_q, addr_d;
    logic [DATA_W-1:0]        dq_q, dq_d, rdata_q, rdata_d;
    logic                     dq_oe_q, dq_oe_d, rv_q, rv_d, err_q, err_d;
    logic [ADDR_W-1:0]        cyc_addr;
    logic [7:0]               cyc_data;

    localparam logic [CNT_W_L-1:0] SETUP_C  = CNT_W_L'(flash_guard_pkg::SETUP_CYC);
    localparam logic [CNT_W_L-1:0] STROBE_C = CNT_W_L'(flash_guard_pkg::STROBE_CYC + 1);
    localparam logic [CNT_W_L-1:0] READ_C   = CNT_W_L'(flash_guard_pkg::READ_CYC);

    // Address and data of the current bus cycle of a multi-cycle sequence
    always_comb
    begin
        logic [11:0] a;
        logic [7:0]  d;
        a = 12'h000;
        d = 8'h00;
        case (op_q)
            flash_guard_pkg::OP_QUERY_ENTER:
            begin
                // Query command address depends on bus width
                a = byte_mode_i ? flash_guard_pkg::ADDR_QUERY_B
                                : flash_guard_pkg::ADDR_QUERY_W;
                d = flash_guard_pkg::CMD_QUERY;
            end
            flash_guard_pkg::OP_RESET:
            begin
                d = flash_guard_pkg::CMD_RESET;
            end
            flash_guard_pkg::OP_SEC_ENTER, flash_guard_pkg::OP_SEC_EXIT:
            begin
                // Unlock pair precedes the final command
                if (step_q == 2'h0)
                begin
                    a = flash_guard_pkg::ADDR_UNLOCK1_W;
                    d = flash_guard_pkg::CMD_UNLOCK1;
                end
                else if (step_q == 2'h1)
                begin
                    a = flash_guard_pkg::ADDR_UNLOCK2_W;
                    d = flash_guard_pkg::CMD_UNLOCK2;
                end
                else if (step_q == 2'h2)
                begin
                    a = flash_guard_pkg::ADDR_UNLOCK1_W;
                    d = (op_q == flash_guard_pkg::OP_SEC_ENTER)
                        ? flash_guard_pkg::CMD_SEC_ENTER : flash_guard_pkg::CMD_SEC_EXIT;
                end
                else
                begin
                    d = flash_guard_pkg::CMD_SEC_EXIT2;
                end
            end
            default:
            begin
                a = 12'h000;
                d = 8'h00;
            end
        endcase
        // Byte-mode unlock addresses are doubled like query addresses
        if (byte_mode_i && op_q != flash_guard_pkg::OP_QUERY_ENTER)
            a = {a[10:0], 1'b0};
        if (op_q == flash_guard_pkg::OP_WRITE || op_q == flash_guard_pkg::OP_READ)
            cyc_addr = uaddr_q;
        else
            cyc_addr = ADDR_W'(a);
        cyc_data = d;
    end

    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        step_d   = step_q;
        nsteps_d = nsteps_q;
        op_d     = op_q;
        uaddr_d  = uaddr_q;
        udata_d  = udata_q;
        mode_d   = mode_q;
        ce_n_d   = ce_n_q;
        we_n_d   = we_n_q;
        oe_n_d   = oe_n_q;
        addr_d   = addr_q;
        dq_d     = dq_q;
        dq_oe_d  = dq_oe_q;
        rdata_d  = rdata_q;
        rv_d     = 1'b0;
        err_d    = err_q;
        // Device lost supply: it now reads array, track that
        if (!supply_ok_i)
            mode_d = flash_guard_pkg::MODE_ARRAY;
        case (state_q)
            S_IDLE:
            begin
                ce_n_d  = 1'b1;
                we_n_d  = 1'b1;
                oe_n_d  = 1'b1;
                dq_oe_d = 1'b0;
                if (req_valid_i)
                begin
                    op_d    = req_op_i;
                    uaddr_d = req_addr_i;
                    udata_d = req_data_i;
                    step_d  = 2'h0;
                    err_d   = 1'b0;
                    nsteps_d = (req_op_i == flash_guard_pkg::OP_SEC_ENTER) ? 2'h2
                             : (req_op_i == flash_guard_pkg::OP_SEC_EXIT)  ? 2'h3 : 2'h0;
                    // No query entry while an embedded operation runs
                    // Writes are pointless below the lockout level
                    if ((req_op_i == flash_guard_pkg::OP_QUERY_ENTER && dev_busy_i) ||
                        (req_op_i != flash_guard_pkg::OP_READ && !supply_ok_i))
                    begin
                        err_d = 1'b1;
                        rv_d  = 1'b1;
                    end
                    else
                    begin
                        // Address settles before the later falling edge
                        state_d = S_SETUP;
                        cnt_d   = SETUP_C;
                    end
                end
            end
            S_SETUP:
            begin
                addr_d = cyc_addr;
                ce_n_d = 1'b0;
                if (op_q == flash_guard_pkg::OP_READ)
                begin
                    oe_n_d  = 1'b0;
                    state_d = S_READ;
                    cnt_d   = READ_C;
                end
                else
                begin
                    // Keep output enable high through every write cycle
                    oe_n_d  = 1'b1;
                    dq_oe_d = 1'b1;
                    dq_d    = (op_q == flash_guard_pkg::OP_WRITE) ? udata_q
                                                                  : DATA_W'(cyc_data);
                    if (cnt_q <= 1)
                    begin
                        we_n_d  = 1'b0;
                        state_d = S_STROBE;
                        cnt_d   = STROBE_C;
                    end
                    else
                        cnt_d = cnt_q - 1'b1;
                end
            end
            S_STROBE:
            begin
                // Strobe held low longer than the glitch filter
                if (cnt_q <= 1)
                begin
                    // Data latched on this rising edge, still driven
                    we_n_d  = 1'b1;
                    state_d = S_HOLD;
                    cnt_d   = SETUP_C;
                end
                else
                    cnt_d = cnt_q - 1'b1;
            end
            S_HOLD:
            begin
                ce_n_d = 1'b1;
                if (cnt_q <= 1)
                begin
                    dq_oe_d = 1'b0;
                    if (step_q < nsteps_q)
                    begin
                        step_d  = step_q + 1'b1;
                        state_d = S_SETUP;
                        cnt_d   = SETUP_C;
                    end
                    else
                    begin
                        state_d = S_IDLE;
                        rv_d    = 1'b1;
                        case (op_q)
                            flash_guard_pkg::OP_QUERY_ENTER:
                                // Remember autoselect as the return mode
                                mode_d = (mode_q == flash_guard_pkg::MODE_AUTOSELECT)
                                       ? flash_guard_pkg::MODE_QUERY_AUTO
                                       : flash_guard_pkg::MODE_QUERY;
                            flash_guard_pkg::OP_RESET:
                                mode_d = (mode_q == flash_guard_pkg::MODE_QUERY_AUTO)
                                       ? flash_guard_pkg::MODE_AUTOSELECT
                                       : flash_guard_pkg::MODE_ARRAY;
                            flash_guard_pkg::OP_SEC_ENTER:
                                mode_d = flash_guard_pkg::MODE_SECURED;
                            flash_guard_pkg::OP_SEC_EXIT:
                                mode_d = flash_guard_pkg::MODE_ARRAY;
                            default:
                                mode_d = mode_q;
                        endcase
                    end
                end
                else
                    cnt_d = cnt_q - 1'b1;
            end
            S_READ:
            begin
                if (cnt_q <= 1)
                begin
                    // Upper byte dropped for query reads and for every byte-mode read
                    if (mode_q == flash_guard_pkg::MODE_QUERY ||
                        mode_q == flash_guard_pkg::MODE_QUERY_AUTO || byte_mode_i)
                        rdata_d = {{(DATA_W-8){1'b0}}, dq_i[7:0]};
                    else
                        rdata_d = dq_i;
                    oe_n_d  = 1'b1;
                    ce_n_d  = 1'b1;
                    rv_d    = 1'b1;
                    state_d = S_IDLE;
                end
                else
                    cnt_d = cnt_q - 1'b1;
            end
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            // Strobes idle high so power-up never looks like a command
            state_q  <= S_IDLE;
            cnt_q    <= '0;
            step_q   <= 2'h0;
            nsteps_q <= 2'h0;
            op_q     <= 3'h0;
            uaddr_q  <= '0;
            udata_q  <= '0;
            mode_q   <= flash_guard_pkg::MODE_ARRAY;
            ce_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            addr_q   <= '0;
            dq_q     <= '0;
            dq_oe_q  <= 1'b0;
            rdata_q  <= '0;
            rv_q     <= 1'b0;
            err_q    <= 1'b0;
        end
        else if (en_i)
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            step_q   <= step_d;
            nsteps_q <= nsteps_d;
            op_q     <= op_d;
            uaddr_q  <= uaddr_d;
            udata_q  <= udata_d;
            mode_q   <= mode_d;
            ce_n_q   <= ce_n_d;
            we_n_q   <= we_n_d;
            oe_n_q   <= oe_n_d;
            addr_q   <= addr_d;
            dq_q     <= dq_d;
            dq_oe_q  <= dq_oe_d;
            rdata_q  <= rdata_d;
            rv_q     <= rv_d;
            err_q    <= err_d;
        end
    end

    assign req_ready_o = (state_q == S_IDLE) && en_i;
    assign rsp_valid_o = rv_q;
    assign rsp_data_o  = rdata_q;
    assign rsp_err_o   = err_q;
    assign mode_o      = 3'(mode_q);
    assign ce_n_o      = ce_n_q;
    assign we_n_o      = we_n_q;
    assign oe_n_o      = oe_n_q;
    assign addr_o      = addr_q;
    assign dq_o        = dq_q;
    assign dq_oe_o     = dq_oe_q;
endmodule
`default_nettype wire

// ---- flash_dev_model.sv ----
// Behavioural flash device answering the host's command cycles and query reads
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        byte_mode_i,
    input  wire logic        busy_i,
    input  wire logic        supply_ok_i,
    output logic      [15:0] dq_o
);
    localparam logic [7:0] QT [23] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A,
        8'h00, 8'h05, 8'h00, 8'h04, 8'h00};
    logic [2:0]  mode_q = 3'h0; // Array read at power-up
    logic [2:0]  step_q = 3'h0;
    logic [15:0] last_q = 16'h0000;
    logic [19:0] wa;
    logic [15:0] rd;
    logic [7:0]  d;
    assign wa = byte_mode_i ? {1'b0, addr_i[19:1]} : addr_i;
    always_comb
    begin
        if (mode_q == 3'h1 || mode_q == 3'h2)
            rd = (wa >= 20'h00010 && wa <= 20'h00026) ? {8'h00, QT[wa - 20'h00010]} : 16'h0000;
        else if (mode_q == 3'h4)
            rd = addr_i[15:0] ^ 16'hC3A5;
        else
            rd = addr_i[15:0] ^ 16'h5A3C;
    end
    // Released bus shows the inverse, so a stale value never passes
    assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last_q;
    always @(posedge oe_n_i or posedge ce_n_i)
        last_q <= rd;
    always @(posedge we_n_i or posedge ce_n_i or negedge supply_ok_i)
    begin
        d = dq_i[7:0];
        if (!supply_ok_i)
        begin
            mode_q <= 3'h0;
            step_q <= 3'h0;
        end
        else if ((!ce_n_i || !we_n_i) && oe_n_i)
        begin
            step_q <= 3'h0;
            if (d == 8'hF0)
                mode_q <= (mode_q == 3'h2) ? 3'h3 : (mode_q == 3'h1) ? 3'h0 : mode_q;
            else if (d == 8'h98 && wa[11:0] == 12'h055 && !busy_i)
                mode_q <= (mode_q == 3'h3) ? 3'h2 : 3'h1;
            // Only the full unlock sequence is decoded, no bypass path
            else if (step_q == 3'h0 && d == 8'hAA && wa[11:0] == 12'h555)
                step_q <= 3'h1;
            else if (step_q == 3'h1 && d == 8'h55 && wa[11:0] == 12'h2AA)
                step_q <= 3'h2;
            else if (step_q == 3'h2 && d == 8'h88 && wa[11:0] == 12'h555)
                mode_q <= 3'h4;
            else if (step_q == 3'h2 && d == 8'h90 && wa[11:0] == 12'h555)
                step_q <= 3'h3;
            else if (step_q == 3'h3 && d == 8'h00)
                mode_q <= 3'h0;
            else if (mode_q != 3'h4) // Secured contents never change
                mode_q <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// ---- flash_guard_host_chk.sv ----
// Bus-pin and refusal-response assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_guard_host_chk #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              req_valid_i,
    input  wire logic              req_ready_o,
    input  wire logic [2:0]        req_op_i,
    input  wire logic              dev_busy_i,
    input  wire logic              supply_ok_i,
    input  wire logic              rsp_valid_o,
    input  wire logic              rsp_err_o,
    input  wire logic              ce_n_o,
    input  wire logic              we_n_o,
    input  wire logic              oe_n_o,
    input  wire logic [ADDR_W-1:0] addr_o,
    input  wire logic [DATA_W-1:0] dq_o,
    input  wire logic              dq_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_write_combo: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
        else $error("write strobe without select or with output enable");
    a_strobe_width: assert property ($fell(we_n_o) |=> !we_n_o)
        else $error("write strobe pulse too short");
    a_latch_stable: assert property (!we_n_o && !$past(we_n_o) |-> $stable(addr_o) && $stable(dq_o))
        else $error("address or data moved during write strobe");
    a_data_at_rise: assert property ($rose(we_n_o) |-> dq_oe_o && $stable(dq_o))
        else $error("data not held at write strobe rise");
    a_no_contention: assert property (!oe_n_o |-> !dq_oe_o)
        else $error("host drives data while output enable low");
    a_busy_refuse: assert property (req_valid_i && req_ready_o && req_op_i == 3'h2 && dev_busy_i
        |=> rsp_valid_o && rsp_err_o)
        else $error("query entry not refused while busy");
    a_supply_refuse: assert property (req_valid_i && req_ready_o && req_op_i != 3'h1 && !supply_ok_i
        |=> rsp_valid_o && rsp_err_o)
        else $error("write not refused under low supply");
    a_refuse_quiet: assert property (req_valid_i && req_ready_o && req_op_i != 3'h1 && !supply_ok_i
        |=> (we_n_o && ce_n_o && !dq_oe_o) [*2])
        else $error("bus cycle started under low supply");
endmodule
bind flash_guard_host flash_guard_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_op_i(req_op_i), .dev_busy_i(dev_busy_i), .supply_ok_i(supply_ok_i),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
    .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

// ---- test_flash_guard_host.sv ----
// Testbench for the flash write-guard and query host controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_guard_host;
    typedef struct packed {logic [15:0] d; logic e; logic [2:0] m; logic cd;} exp_t;
    localparam logic [7:0] QT [23] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A,
        8'h00, 8'h05, 8'h00, 8'h04, 8'h00};
    logic        clk_i = 1'b0, srst_i = 1'b1, en_i = 1'b1, req_valid_i = 1'b0;
    logic        byte_mode_i = 1'b0, dev_busy_i = 1'b0, supply_ok_i = 1'b1;
    logic [2:0]  req_op_i = 3'h0;
    logic [19:0] req_addr_i = 20'h00000, a;
    logic [15:0] req_data_i = 16'h0000;
    wire  [15:0] rsp_data_o, dq_o, dq_i;
    wire  [19:0] addr_o;
    wire  [2:0]  mode_o;
    wire         req_ready_o, rsp_valid_o, rsp_err_o, ce_n_o, we_n_o, oe_n_o, dq_oe_o;
    exp_t        exp_q [$];
    exp_t        x;
    int          n_fail = 0, n_checks = 0, n_rsp = 0, i;
    always #2.5 clk_i = ~clk_i;
    flash_guard_host i_dut (.clk_i(clk_i), .srst_i(srst_i), .en_i(en_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_data_i(req_data_i), .byte_mode_i(byte_mode_i),
        .dev_busy_i(dev_busy_i), .supply_ok_i(supply_ok_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .mode_o(mode_o), .ce_n_o(ce_n_o),
        .we_n_o(we_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
        .dq_i(dq_i));
    flash_dev_model i_dev (.ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o),
        .dq_i(dq_o), .byte_mode_i(byte_mode_i), .busy_i(dev_busy_i), .supply_ok_i(supply_ok_i),
        .dq_o(dq_i));
    function automatic exp_t ex(logic [15:0] d, logic e, logic [2:0] m, logic cd);
        return '{d, e, m, cd};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, then wait for its answer before the next
    task automatic go(input logic [2:0] op, input logic [19:0] ad, input exp_t e);
        int r;
        int k;
        r = n_rsp;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1)
            @(negedge clk_i);
        exp_q.push_back(e);
        req_valid_i = 1'b1;
        req_op_i = op;
        req_addr_i = ad;
        req_data_i = 16'($urandom);
        @(negedge clk_i);
        req_valid_i = 1'b0;
        for (k = 0; k < 200 && n_rsp == r; k++)
            @(negedge clk_i);
        chk(32'(n_rsp - r), 32'h1);
    endtask
    logic        en_p = 1'b1;
    always @(posedge clk_i)
        en_p <= en_i;
    // A pulse held over by a frozen clock enable is the same answer
    always @(negedge clk_i)
        if (rsp_valid_o === 1'b1 && en_p === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
            begin
                x = exp_q.pop_front();
                n_rsp++;
                if (x.cd)
                    chk(32'(rsp_data_o), 32'(x.d));
                chk(32'(rsp_err_o), 32'(x.e));
                chk(32'(mode_o), 32'(x.m));
            end
        end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        void'($urandom(5));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            byte_mode_i = b[0];
            go(3'h2, 20'h00000, ex(16'h0000, 1'b0, 3'h1, 1'b0));
            for (i = 16; i <= 38; i++)
                go(3'h1, 20'(i << b), ex({8'h00, QT[i - 16]}, 1'b0, 3'h1, 1'b1));
            go(3'h3, 20'h00000, ex(16'h0000, 1'b0, 3'h0, 1'b0));
            go(3'h1, 20'h00010, ex(b ? 16'h002C : 16'h5A2C, 1'b0, 3'h0, 1'b1));
            $display("test query pass %0d done", b);
        end
        byte_mode_i = 1'b0;
        dev_busy_i = 1'b1;
        go(3'h2, 20'h00000, ex(16'h0000, 1'b1, 3'h0, 1'b0));
        dev_busy_i = 1'b0;
        supply_ok_i = 1'b0;
        for (i = 0; i < 6; i++)
            if (i != 1)
                go(3'(i), 20'h00123, ex(16'h0000, 1'b1, 3'h0, 1'b0));
        go(3'h1, 20'h00123, ex(16'h0123 ^ 16'h5A3C, 1'b0, 3'h0, 1'b1));
        supply_ok_i = 1'b1;
        $display("test refusals done");
        go(3'h4, 20'h00000, ex(16'h0000, 1'b0, 3'h4, 1'b0));
        go(3'h0, 20'h00005, ex(16'h0000, 1'b0, 3'h4, 1'b0));
        go(3'h1, 20'h00005, ex(16'h0005 ^ 16'hC3A5, 1'b0, 3'h4, 1'b1));
        go(3'h5, 20'h00000, ex(16'h0000, 1'b0, 3'h0, 1'b0));
        go(3'h1, 20'h00005, ex(16'h0005 ^ 16'h5A3C, 1'b0, 3'h0, 1'b1));
        $display("test secured region done");
        for (i = 0; i < 8; i++)
        begin
            a = 20'($urandom);
            fork
                go(3'h1, a, ex(a[15:0] ^ 16'h5A3C, 1'b0, 3'h0, 1'b1));
                begin
                    // On even passes the freeze lands in the middle of the read
                    repeat (3 + i) @(negedge clk_i);
                    en_i = i[0];
                    repeat (4) @(negedge clk_i);
                    en_i = 1'b1;
                end
            join
        end
        $display("test random reads done");
        chk(32'(exp_q.size()), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
